// ===== hw/bac_comparators.sv
// Breakpoint comparators A and B with AHB-Lite register slave.
// Assumes core bus sampled on sys_clk; secure is a same-clock level.
//
// Operation
// - Dual mask x:0 full compare, 0:1 drops low byte; extended only if paged.
// - Dual mask 1:1 compares only extended page bits, 64K window on ROM breakpoints and on trace page 01; no match otherwise.
// - Full mode B mask: 0:0 both, 0:1 high, 1:0 low, 1:1 none.
// - Full mode ignores comparator B extended register.
// - Trace mode: page select bits 7:6 choose extended compare.
// - Upper page select bit ignored; 10 and 11 act as 00, 01.
// - Breakpoint mode: ROM access compares page and 13:8, else 15:8.
// - Trace mode page 01 compares bits 21:16 and 15:8; 00 none.
// - Each unmasked comparator A value bit demands equal address bit, except 15:14 on ROM breakpoints.
// - Breakpoint-enable bit selects breakpoint mode.
// - Trace-enable selects trace mode unless breakpoint-enable set.
// - Secured device never enables trace mode.
// - Dual mask 1:0 treated as full compare.
// - Cycle qualify on: type 0 matches writes, 1 matches reads.
`timescale 1ns/1ps
module bac_comparators (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire bac_pkg::bac_bus_type coreBus,
  input  wire logic              secure,
  output logic                   matchA,
  output logic                   matchB,
  output logic                   breakpointMode,
  output logic                   traceMode
);
  logic [7:0]  ctrlOne_reg;
  logic [7:0]  ctrlTwo_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  aExt_reg;
  logic [7:0]  bExt_reg;
  logic [15:0] aAddr_reg;
  logic [15:0] bValue_reg;
  logic        wrPend_reg;
  logic [7:0]  wrAddr_reg;
  logic [31:0] readWord;
  logic        readTake;
  logic        matchA_next;
  logic        matchB_next;
  logic        bkpNext;
  logic        trcNext;
  logic        fullMode;
  logic        dataOk;
  logic        modeOn;
  // Per-comparator view, index 0 is A and 1 is B
  logic [7:0]  cmpExt  [2];
  logic [15:0] cmpVal  [2];
  logic [1:0]  cmpMask [2];
  logic [1:0]  cmpQual [2];
  logic [1:0]  addrOk;
  logic [1:0]  cycleOk;

  // Bus slave: zero wait, always OKAY; a write lands one edge after its address
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrPend_reg <= 1'b0;
    end else if (hready) begin
      wrPend_reg <= hsel && htrans[1] && hwrite;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrAddr_reg <= 8'h00;
    end else if (hready) begin
      wrAddr_reg <= haddr[7:0];
    end
  end

  // Register writes, one process per register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrlOne_reg <= bac_pkg::RESET_BYTE;
    end else if (wrPend_reg && wrAddr_reg == bac_pkg::OFF_CTRL_ONE) begin
      ctrlOne_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrlTwo_reg <= bac_pkg::RESET_BYTE;
    end else if (wrPend_reg && wrAddr_reg == bac_pkg::OFF_CTRL_TWO) begin
      ctrlTwo_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mask_reg <= bac_pkg::RESET_BYTE;
    end else if (wrPend_reg && wrAddr_reg == bac_pkg::OFF_MASK) begin
      mask_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aExt_reg <= bac_pkg::RESET_BYTE;
    end else if (wrPend_reg && wrAddr_reg == bac_pkg::OFF_A_EXT) begin
      aExt_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aAddr_reg <= bac_pkg::RESET_WORD;
    end else if (wrPend_reg && wrAddr_reg == bac_pkg::OFF_A_ADDR) begin
      aAddr_reg <= hwdata[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bExt_reg <= bac_pkg::RESET_BYTE;
    end else if (wrPend_reg && wrAddr_reg == bac_pkg::OFF_B_EXT) begin
      bExt_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bValue_reg <= bac_pkg::RESET_WORD;
    end else if (wrPend_reg && wrAddr_reg == bac_pkg::OFF_B_VALUE) begin
      bValue_reg <= hwdata[15:0];
    end
  end

  // Read decode for the address phase being taken
  always_comb begin
    readTake = hready && hsel && htrans[1] && !hwrite;
    if (haddr[7:0] == bac_pkg::OFF_CTRL_ONE) begin
      readWord = {24'h00_0000, ctrlOne_reg};
    end else if (haddr[7:0] == bac_pkg::OFF_CTRL_TWO) begin
      readWord = {24'h00_0000, ctrlTwo_reg};
    end else if (haddr[7:0] == bac_pkg::OFF_MASK) begin
      readWord = {24'h00_0000, mask_reg};
    end else if (haddr[7:0] == bac_pkg::OFF_A_EXT) begin
      readWord = {24'h00_0000, aExt_reg};
    end else if (haddr[7:0] == bac_pkg::OFF_A_ADDR) begin
      readWord = {16'h0000, aAddr_reg};
    end else if (haddr[7:0] == bac_pkg::OFF_B_EXT) begin
      readWord = {24'h00_0000, bExt_reg};
    end else if (haddr[7:0] == bac_pkg::OFF_B_VALUE) begin
      readWord = {16'h0000, bValue_reg};
    end else if (haddr[7:0] == bac_pkg::OFF_STATUS) begin
      readWord = {28'h000_0000, matchB, matchA, traceMode, breakpointMode};
    end else begin
      readWord = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (readTake) begin
      hrdata <= readWord;
    end
  end

  // Fixed answer: no wait states, no errors
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Mode selection
  always_comb begin
    bkpNext = ctrlTwo_reg[bac_pkg::BIT_BKP_EN];
    trcNext = ctrlOne_reg[bac_pkg::BIT_TRACE_EN] && !bkpNext && !secure;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      breakpointMode <= 1'b0;
    end else begin
      breakpointMode <= bkpNext;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      traceMode <= 1'b0;
    end else begin
      traceMode <= trcNext;
    end
  end

  always_comb begin
    cmpExt[0]  = aExt_reg;
    cmpExt[1]  = bExt_reg;
    cmpVal[0]  = aAddr_reg;
    cmpVal[1]  = bValue_reg;
    cmpMask[0] = {mask_reg[bac_pkg::BIT_A_MASK_HI], mask_reg[bac_pkg::BIT_A_MASK_LO]};
    cmpMask[1] = {mask_reg[bac_pkg::BIT_B_MASK_HI], mask_reg[bac_pkg::BIT_B_MASK_LO]};
    cmpQual[0] = {mask_reg[bac_pkg::BIT_A_QUAL], mask_reg[bac_pkg::BIT_A_TYPE]};
    cmpQual[1] = {mask_reg[bac_pkg::BIT_B_QUAL], mask_reg[bac_pkg::BIT_B_TYPE]};
  end

  // Address compare, one copy per comparator
  for (genvar i = 0; i < 2; i++) begin : gen_cmp
    logic extUse;
    logic extOk;
    logic hiOk;
    logic loOk;
    logic useHi;
    logic useLo;

    // Extended compare and high-byte span by mode
    always_comb begin
      extUse = 1'b0;
      hiOk   = (cmpVal[i][15:8] == coreBus.addr[15:8]);
      if (bkpNext && coreBus.romAccess) begin
        extUse = 1'b1;
        hiOk   = (cmpVal[i][13:8] == coreBus.addr[13:8]);
      end else if (trcNext && cmpExt[i][bac_pkg::BIT_PAGE_LO]) begin
        extUse = 1'b1;
      end
    end

    // Mask pair decode
    always_comb begin
      extOk = !extUse || (cmpExt[i][5:0] == coreBus.page);
      loOk  = (cmpVal[i][7:0] == coreBus.addr[7:0]);
      useLo = !cmpMask[i][0];
      useHi = !(cmpMask[i][1] && cmpMask[i][0]);
    end

    assign addrOk[i]  = extOk && (!useHi || hiOk) && (!useLo || loOk)
                        && (extUse || useHi);
    assign cycleOk[i] = !cmpQual[i][1] || (cmpQual[i][0] == coreBus.read);
  end

  // Full-mode data compare with byte-lane masks
  always_comb begin
    dataOk = 1'b1;
    if (!mask_reg[bac_pkg::BIT_B_MASK_HI]) begin
      dataOk = dataOk && (bValue_reg[15:8] == coreBus.data[15:8]);
    end
    if (!mask_reg[bac_pkg::BIT_B_MASK_LO]) begin
      dataOk = dataOk && (bValue_reg[7:0] == coreBus.data[7:0]);
    end
  end

  // Match conditions per comparator
  always_comb begin
    fullMode    = ctrlTwo_reg[bac_pkg::BIT_FULL_MODE] && bkpNext;
    modeOn      = coreBus.valid && (bkpNext || trcNext);
    matchA_next = modeOn && addrOk[0] && cycleOk[0];
    if (fullMode) begin
      // B compares data; its extended register is unused
      matchB_next = matchA_next && dataOk;
    end else begin
      matchB_next = modeOn && addrOk[1] && cycleOk[1];
    end
  end

  // One pulse per qualifying bus cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      matchA <= 1'b0;
    end else begin
      matchA <= matchA_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      matchB <= 1'b0;
    end else begin
      matchB <= matchB_next;
    end
  end
endmodule

// ===== hw/bac_pkg.sv
// Package for the breakpoint address/data comparators.
// Assumes AHB-Lite word access; offsets are byte addresses.
package bac_pkg;
  localparam logic [7:0] OFF_CTRL_ONE  = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO  = 8'h04;
  localparam logic [7:0] OFF_MASK      = 8'h08;
  localparam logic [7:0] OFF_A_EXT     = 8'h0C;
  localparam logic [7:0] OFF_A_ADDR    = 8'h10;
  localparam logic [7:0] OFF_B_EXT     = 8'h14;
  localparam logic [7:0] OFF_B_VALUE   = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1C;
  // Control one fields
  localparam int BIT_TRACE_EN   = 0;
  // Control two fields
  localparam int BIT_BKP_EN     = 0;
  localparam int BIT_FULL_MODE  = 1;
  // Mask register fields
  localparam int BIT_A_MASK_HI  = 7;
  localparam int BIT_A_MASK_LO  = 6;
  localparam int BIT_B_MASK_HI  = 5;
  localparam int BIT_B_MASK_LO  = 4;
  localparam int BIT_A_QUAL     = 3;
  localparam int BIT_A_TYPE     = 2;
  localparam int BIT_B_QUAL     = 1;
  localparam int BIT_B_TYPE     = 0;
  // Extended register fields
  localparam int BIT_PAGE_LO    = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef struct packed {
    logic [15:0] addr;
    logic [5:0]  page;
    logic [15:0] data;
    logic        read;
    logic        valid;
    logic        romAccess;
  } bac_bus_type;
endpackage

// ===== dv/bac_properties.sv
// Checker: bus answer, match timing and mode properties.
// Assumes binding into bac_comparators on its one clock.
`timescale 1ns/1ps
module bac_checker (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire bac_pkg::bac_bus_type coreBus,
  input wire logic        secure,
  input wire logic        matchA,
  input wire logic        matchB,
  input wire logic        breakpointMode,
  input wire logic        traceMode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic wrPhase;
  always_ff @(posedge sys_clk) wrPhase <= hsel && hready && htrans[1] && hwrite;
  sequence farRead; hsel && hready && htrans[1] && !hwrite && haddr[7:0] > 8'h1C; endsequence
  sequence allQuiet; hreadyout && !matchA && !matchB && !breakpointMode && !traceMode; endsequence
  okay_resp_a: assert property (!hresp)
    else $error("hresp not OKAY");
  reset_quiet_a: assert property ($fell(srst) |-> allQuiet)
    else $error("outputs set after reset");
  far_read_a: assert property (farRead |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  match_a_src_a: assert property (matchA |-> $past(coreBus.valid))
    else $error("stray matchA");
  match_b_src_a: assert property (matchB |-> $past(coreBus.valid))
    else $error("stray matchB");
  one_mode_a: assert property (!(breakpointMode && traceMode))
    else $error("both modes on");
  secure_block_a: assert property ($past(secure) && $past(secure, 2) |-> !traceMode)
    else $error("trace while secured");
  bkp_source_a: assert property ($changed(breakpointMode) |-> $past(wrPhase) || $past(wrPhase, 2))
    else $error("mode moved without write");
endmodule
bind bac_comparators bac_checker chk (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .coreBus, .secure, .matchA, .matchB,
  .breakpointMode, .traceMode);

// ===== dv/bac_core_model.sv
// Core bus model: one bus cycle per request.
// Assumes one caller at a time.
`timescale 1ns/1ps
module bac_core_model (
  input  wire logic            sys_clk,
  output bac_pkg::bac_bus_type coreBus
);
  initial coreBus = '0;
  task automatic cyc(input bac_pkg::bac_bus_type b);
    @(posedge sys_clk);
    coreBus <= b;
    @(posedge sys_clk);
    // Idle fields inverted so stale values never match
    coreBus <= ~b;
  endtask
endmodule

// ===== dv/tb.sv
// Testbench: comparator case table over AHB-Lite and the core bus.
// Assumes bac_comparators, bac_core_model and the bac_pkg map.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [3:0]  ab, cfg, rr;
    logic [7:0]  page, mask, aExt;
    logic [15:0] addr, data;
  } bac_case_type;
  logic                 sys_clk = 1'h0, srst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic                 secure = 1'h0, pend = 1'h0;
  logic [1:0]           htrans = 2'h0;
  logic [31:0]          haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic                 hreadyout, hresp, matchA, matchB, bkpM, trcM;
  bac_pkg::bac_bus_type coreBus;
  logic [3:0]           q [$];
  int                   n_mismatch = 0, n_checks = 0, cycles = 0;
  // Fields: {A,B} | cfg {secure,trace,full,bkp}, {read,rom}, page | mask, ext | addr | data
  bac_case_type tc [22] = '{
    68'h2_1000_0000_1234_0000, 68'h2_1000_4000_12FF_0000, // Dual
    68'h0_1000_8000_12FF_0000, 68'h0_1000_C000_FFFE_0000, // Dual
    68'h2_1105_C005_8000_0000, 68'h2_1105_0005_D234_0000, // Paged
    68'h0_1106_0005_D234_0000, 68'h0_1000_0C00_1234_0000, // Paged, qualify
    68'h2_1200_0C00_1234_0000, 68'h1_1000_0000_FFFF_0000, // Qualify, B
    68'h3_3105_0005_1234_ABCD, 68'h3_3000_1000_1234_ABFF, // Full
    68'h3_3000_2000_1234_FFCD, 68'h3_3000_3000_1234_0000, // Full
    68'h2_3000_0000_1234_ABCC, 68'h2_4005_0045_1234_0000, // Full, trace
    68'h0_4006_0045_1234_0000, 68'h0_4006_00C5_1234_0000, // Trace
    68'h2_4006_0085_1234_0000, 68'h2_4006_0005_1234_0000, // Trace
    68'h0_C006_0005_1234_0000, 68'h2_5006_0000_1234_0000}; // Secure, override
  bac_comparators dut (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .coreBus, .secure, .matchA,
    .matchB, .breakpointMode(bkpM), .traceMode(trcM));
  bac_core_model core (.sys_clk, .coreBus);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'h0, a, 32'h0000_0000, r);
    chk(r & m, e);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      end_sim;
    end
  end
  always @(negedge sys_clk) begin
    if (pend) chk({30'h0, matchA, matchB}, {28'h0, q.pop_front()});
    pend = coreBus.valid;
  end
  initial begin
    bac_case_type c;
    logic [31:0]  e;
    logic [15:0]  d;
    logic [7:0]   a;
    void'($urandom(82));
    repeat (16) @(posedge sys_clk);
    srst <= 1'h0;
    rd(bac_pkg::OFF_A_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(bac_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    a = 8'h20 + 8'($urandom_range(55)) * 8'h04;
    wr(a, $urandom);
    rd(a, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("reset and map test done");
    wr(bac_pkg::OFF_A_ADDR, 32'h0000_1234);
    wr(bac_pkg::OFF_B_EXT, 32'h0000_003F);
    foreach (tc[i]) begin
      c = tc[i];
      secure <= c.cfg[3];
      wr(bac_pkg::OFF_CTRL_ONE, {31'h0, c.cfg[2]});
      wr(bac_pkg::OFF_CTRL_TWO, {30'h0, c.cfg[1:0]});
      wr(bac_pkg::OFF_MASK, {24'h00_0000, c.mask});
      wr(bac_pkg::OFF_A_EXT, {24'h00_0000, c.aExt});
      wr(bac_pkg::OFF_B_VALUE, {16'h0000, c.cfg[1] ? 16'hABCD : 16'hFFFF});
      e = {30'h0, c.cfg[2] & ~c.cfg[0] & ~c.cfg[3], c.cfg[0]};
      rd(bac_pkg::OFF_STATUS, 32'h0000_0003, e);
      chk({30'h0, trcM, bkpM}, e);
      d = c.data ^ (c.cfg[1] ? 16'h0000 : 16'($urandom));
      q.push_back(c.ab);
      core.cyc({c.addr, c.page[5:0], d, c.rr[1], 1'h1, c.rr[0]});
      $display("case %0d done", i);
    end
    repeat (4) @(posedge sys_clk);
    end_sim;
  end
endmodule
